//--- dme_mac_engine.sv
// Notes on behaviour
// - Widen 16-bit operands to 17 bits: zero for unsigned, sign for signed.
// - Product is 33 bits, sign-extended to 40 before the accumulator path.
// - Fractional mode with signed data shifts Q15 product to 1.31; otherwise plain integer.
// - Integer product: signed, unsigned, mixed; bytes give 16 bits, words 32.
// - Adder reads the selected accumulator and writes back to the same one.
// - Accumulator load and add may scale the operand through the barrel shifter.
// - Add uses true data, carry-in low; subtract complements, borrow active low.
// - Adder passes, except in 32-bit saturation, set target guard flag when bits 39..32 differ.
// - Guard flag with its enable raises the arithmetic warning trap.
// - Clip flags set by adder overflow, cleared only by software write.
// - Saturation off: clip flags track bit 39 overflow; trap if enabled.
// - Status shows OR of guard flags and OR of clip flags.
// - 40-bit mode: bit 39 overflow loads max positive or negative, sets flag.
// - 32-bit mode: bit 31 overflow loads 1.31 limits; guard flags stay clear.
// - Catastrophic mode wraps, sets clip flag on bit 39, traps if enabled.
// - Saturation uses sum, overflow, per-accumulator enables and width select.
// - Config holds fractional, sign, round, clip enables, write clip, width.
// - Accumulator add, subtract and negate need no outside operand.
// - Write-back class ops may store rounded high word of other accumulator.
// - Write-back to pointer register directly, or to its address then add 2.
module dme_mac_engine
  import dme_pkg::*;
(
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // X bus write-back
  output logic             xbus_wr_en,
  output logic      [15:0] xbus_addr,
  output logic      [15:0] xbus_wdata,
  // Trap
  output logic             arith_trap
);

  logic [7:0]  cfg_reg;
  logic [2:0]  trap_reg;
  logic [39:0] acc_a_reg,  acc_b_reg;
  logic [15:0] x_reg,      y_reg;
  logic [31:0] iprod_reg;
  logic [15:0] ptr_reg;
  logic        guard_a_reg, guard_b_reg, clip_a_reg, clip_b_reg;
  logic        xwr_reg;
  logic [15:0] xaddr_reg,  xdata_reg;

  // Bus decode
  wire       wr_en   = psel & penable & pwrite;
  wire       sel_cfg = paddr == DME_OFF_CFG;
  wire       sel_trp = paddr == DME_OFF_TRAP;
  wire       sel_st  = paddr == DME_OFF_STAT;
  wire       sel_op  = paddr == DME_OFF_OPND;
  wire       sel_cmd = paddr == DME_OFF_CMD;
  wire       sel_ptr = paddr == DME_OFF_WBPTR;
  wire       mapped  = sel_cfg | sel_trp | sel_st | sel_op | sel_cmd | sel_ptr |
                       paddr == DME_OFF_ACCUMULATOR_A_L | paddr == DME_OFF_ACCUMULATOR_A_H |
                       paddr == DME_OFF_ACCUMULATOR_B_L | paddr == DME_OFF_ACCUMULATOR_B_H |
                       paddr == DME_OFF_IPROD;
  wire       exec    = wr_en & sel_cmd;

  // Command decode from the write that launches it
  wire dme_op_e op   = dme_op_e'(pwdata[3:0]);
  wire       tgt     = pwdata[DME_CMD_TGT];
  wire dme_wb_e wbm  = dme_wb_e'(pwdata[DME_CMD_WBM_L +: 2]);
  wire [4:0] shamt   = pwdata[DME_CMD_SH_L +: 5];
  wire       x_uns   = pwdata[DME_CMD_XUNS];
  wire       y_uns   = pwdata[DME_CMD_YUNS];
  wire       byte_op = pwdata[DME_CMD_BYTE];

  // Config fields
  wire       frac    = cfg_reg[DME_CFG_FRAC];
  wire       uns     = cfg_reg[DME_CFG_UNS];
  wire       w40     = cfg_reg[DME_CFG_W40];
  wire       sat_a   = cfg_reg[DME_CFG_CLIPA];
  wire       sat_b   = cfg_reg[DME_CFG_CLIPB];

  function automatic logic [16:0] ext17(input logic [15:0] v, input logic u);
    ext17 = {~u & v[15], v};
  endfunction

  function automatic logic not_same(input logic [8:0] v);
    not_same = ~(&v | ~|v);
  endfunction

  // Multiplier operand select
  wire [16:0] xe    = ext17(x_reg, uns);
  wire [16:0] ye    = ext17(y_reg, uns);
  wire [16:0] diff  = xe - ye;
  wire        is_int = op == DME_IPROD;
  wire        is_sq  = op == DME_SQAC;
  wire        is_dsq = op == DME_DSQ | op == DME_DSQAC;
  wire [16:0] xi    = byte_op ? {{9{~x_uns & x_reg[7]}}, x_reg[7:0]} : ext17(x_reg, x_uns);
  wire [16:0] yi    = byte_op ? {{9{~y_uns & y_reg[7]}}, y_reg[7:0]} : ext17(y_reg, y_uns);
  wire [16:0] mul_a = is_int ? xi : is_dsq ? diff : xe;
  wire [16:0] mul_b = is_int ? yi : is_dsq ? diff : is_sq ? xe : ye;

  // 17x17 product, scaler and sign extension
  wire signed [33:0] prod_full = $signed(mul_a) * $signed(mul_b);
  wire [32:0] prod33 = prod_full[32:0];
  wire [32:0] scaled = (frac & ~uns) ? {prod33[31:0], 1'b0} : prod33;
  wire [39:0] prod40 = {{7{scaled[32]}}, scaled};
  wire [31:0] ires   = byte_op ? {16'h0000, prod33[15:0]} : prod33[31:0];

  // Barrel shift of a loaded word: positive right, negative left
  wire signed [39:0] ld_base = {{8{x_reg[15]}}, x_reg, 16'h0000};
  wire [4:0]         sh_mag  = shamt[4] ? 5'(-shamt) : shamt;
  wire [39:0]        ld_val  = shamt[4] ? 40'(ld_base <<< sh_mag)
                                        : 40'(ld_base >>> sh_mag);

  wire [39:0] acc_t = tgt ? acc_b_reg : acc_a_reg;
  wire [39:0] acc_o = tgt ? acc_a_reg : acc_b_reg;

  // Adder input select
  logic        uses_add, zero_a, sub;
  logic [39:0] b40;
  always_comb begin
    uses_add = 1'b1;
    zero_a   = 1'b0;
    sub      = 1'b0;
    b40      = prod40;
    unique case (op)
      DME_ZERO:    begin zero_a = 1'b1; b40 = 40'h0; end
      DME_PLOAD:   zero_a = 1'b1;
      DME_NPLOAD:  begin zero_a = 1'b1; sub = 1'b1; end
      DME_MAC:     ;
      DME_MSC:     sub = 1'b1;
      DME_SQAC:    ;
      DME_DSQ:     zero_a = 1'b1;
      DME_DSQAC:   ;
      DME_ALOAD:   begin zero_a = 1'b1; b40 = ld_val; end
      DME_AADD:    b40 = ld_val;
      DME_ACCADD:  b40 = acc_o;
      DME_ACCSUB:  begin b40 = acc_o; sub = 1'b1; end
      DME_ACCNEG:  begin zero_a = 1'b1; b40 = acc_t; sub = 1'b1; end
      DME_NOP, DME_IPROD, DME_PFSTORE: uses_add = 1'b0;
    endcase
  end

  // 40-bit adder: complement plus active-low borrow for subtract
  wire [39:0] a40  = zero_a ? 40'h0 : acc_t;
  wire [39:0] bin  = sub ? ~b40 : b40;
  wire [40:0] sum  = {a40[39], a40} + {bin[39], bin} + {40'h0, sub};
  wire        ov39 = sum[40] ^ sum[39];
  wire        ov31 = not_same(sum[40:32]) | (sum[40] ^ sum[31]);
  wire        sat_en = tgt ? sat_b : sat_a;

  // Saturation decision
  logic [39:0] res;
  logic        clip_evt;
  always_comb begin
    res      = sum[39:0];
    clip_evt = ov39;
    if (sat_en && w40) begin
      if (ov39) res = sum[40] ? DME_NEG40 : DME_POS40;
    end else if (sat_en) begin
      clip_evt = ov31;
      if (ov31) res = sum[40] ? DME_NEG32 : DME_POS32;
    end
  end
  wire guard_evt = ~(sat_en & ~w40) & not_same(res[39:31]) & not_same({res[39:32], res[39]});

  // Rounded high word of the non-target accumulator
  wire        rnd_conv = cfg_reg[DME_CFG_RND];
  wire        rnd_inc  = (rnd_conv && acc_o[15:0] == DME_HALF) ? acc_o[16] : acc_o[15];
  wire [15:0] wb_word  = acc_o[31:16] + {15'h0, rnd_inc};
  wire        wb_ok    = op == DME_MAC | op == DME_MSC | op == DME_ZERO | op == DME_PFSTORE;
  wire        wb_dir   = exec & wb_ok & wbm == DME_WB_DIRECT;
  wire        wb_ind   = exec & wb_ok & wbm == DME_WB_INDIRECT;

  // Flag next values: hardware set wins over software clear
  wire        upd_a  = exec & uses_add & ~tgt;
  wire        upd_b  = exec & uses_add & tgt;
  wire        clr_a  = wr_en & sel_st & pwdata[DME_ST_CA];
  wire        clr_b  = wr_en & sel_st & pwdata[DME_ST_CB];
  wire        clip_a_next = (upd_a & clip_evt) | (clip_a_reg & ~clr_a);
  wire        clip_b_next = (upd_b & clip_evt) | (clip_b_reg & ~clr_b);
  wire        guard_any = guard_a_reg | guard_b_reg;
  wire        clip_any  = clip_a_reg | clip_b_reg;

  // Trap is a level; the core's exception logic takes it
  wire trap_next = (guard_a_reg & trap_reg[DME_TRAP_GA]) |
                   (guard_b_reg & trap_reg[DME_TRAP_GB]) |
                   (trap_reg[DME_TRAP_CAT] &
                    ((clip_a_reg & ~sat_a) | (clip_b_reg & ~sat_b)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg  <= DME_CFG_RST;
      trap_reg <= DME_TRAP_RST;
      x_reg    <= 16'h0000;
      y_reg    <= 16'h0000;
    end else if (wr_en) begin
      if (sel_cfg) cfg_reg <= pwdata[7:0];
      if (sel_trp) trap_reg <= pwdata[2:0];
      if (sel_op) begin
        x_reg <= pwdata[15:0];
        y_reg <= pwdata[31:16];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_a_reg   <= 40'h00_0000_0000;
      acc_b_reg   <= 40'h00_0000_0000;
      guard_a_reg <= 1'b0;
      guard_b_reg <= 1'b0;
    end else begin
      if (upd_a) begin
        acc_a_reg   <= res;
        guard_a_reg <= guard_evt;
      end
      if (upd_b) begin
        acc_b_reg   <= res;
        guard_b_reg <= guard_evt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clip_a_reg <= 1'b0;
      clip_b_reg <= 1'b0;
      iprod_reg  <= 32'h0000_0000;
      arith_trap <= 1'b0;
    end else begin
      clip_a_reg <= clip_a_next;
      clip_b_reg <= clip_b_next;
      arith_trap <= trap_next;
      if (exec && is_int) iprod_reg <= ires;
    end
  end

  // Pointer: software write, direct write-back, or post-increment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_reg   <= 16'h0000;
      xwr_reg   <= 1'b0;
      xaddr_reg <= 16'h0000;
      xdata_reg <= 16'h0000;
    end else begin
      xwr_reg <= wb_ind;
      if (wr_en && sel_ptr) ptr_reg <= pwdata[15:0];
      else if (wb_dir) ptr_reg <= wb_word;
      else if (wb_ind) ptr_reg <= ptr_reg + DME_WB_STEP;
      if (wb_ind) begin
        xaddr_reg <= ptr_reg;
        xdata_reg <= wb_word;
      end
    end
  end

  assign xbus_wr_en = xwr_reg;
  assign xbus_addr  = xaddr_reg;
  assign xbus_wdata = xdata_reg;

  // Zero-wait slave; read data is a mux of flip-flops
  wire [31:0] stat_w = {25'h0, arith_trap, clip_any, guard_any,
                        clip_b_reg, clip_a_reg, guard_b_reg, guard_a_reg};
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = sel_cfg                 ? {24'h0, cfg_reg} :
                   sel_trp                 ? {29'h0, trap_reg} :
                   sel_st                  ? stat_w :
                   paddr == DME_OFF_ACCUMULATOR_A_L ? acc_a_reg[31:0] :
                   paddr == DME_OFF_ACCUMULATOR_A_H ? {24'h0, acc_a_reg[39:32]} :
                   paddr == DME_OFF_ACCUMULATOR_B_L ? acc_b_reg[31:0] :
                   paddr == DME_OFF_ACCUMULATOR_B_H ? {24'h0, acc_b_reg[39:32]} :
                   sel_op                  ? {y_reg, x_reg} :
                   paddr == DME_OFF_IPROD  ? iprod_reg :
                   sel_ptr                 ? {16'h0, ptr_reg} : 32'h0000_0000;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_uns_ext;
    exec && op == DME_PLOAD && uns |-> mul_a[16] == 1'b0 && mul_b[16] == 1'b0;
  endproperty
  a_uns_ext: assert property (p_uns_ext) else $error("unsigned operand not zero-extended");

  // Integer load must land the full signed product, sign-extended to 40 bits
  property p_prod_ext;
    exec && op == DME_PLOAD && !tgt && !sat_a && !(frac && !uns) |=>
      $signed(acc_a_reg) == $signed($past(mul_a)) * $signed($past(mul_b));
  endproperty
  a_prod_ext: assert property (p_prod_ext) else $error("product not sign-extended");

  property p_other_kept;
    upd_a |=> acc_b_reg == $past(acc_b_reg) && guard_b_reg == $past(guard_b_reg);
  endproperty
  a_other_kept: assert property (p_other_kept) else $error("non-target accumulator changed");

  property p_guard_a;
    upd_a && !(sat_a && !w40) |=> guard_a_reg == not_same({acc_a_reg[39:32], acc_a_reg[39]});
  endproperty
  a_guard_a: assert property (p_guard_a) else $error("guard flag wrong after pass");

  property p_guard_trap;
    guard_b_reg && trap_reg[DME_TRAP_GB] |=> arith_trap;
  endproperty
  a_guard_trap: assert property (p_guard_trap) else $error("guard trap missing");

  property p_clip_sticky;
    clip_a_reg && !clr_a |=> clip_a_reg;
  endproperty
  a_clip_sticky: assert property (p_clip_sticky) else $error("clip flag cleared by hardware");

  property p_cat_trap;
    clip_a_reg && !sat_a && trap_reg[DME_TRAP_CAT] |=> arith_trap;
  endproperty
  a_cat_trap: assert property (p_cat_trap) else $error("catastrophic trap missing");

  property p_any_read;
    psel && sel_st |-> prdata[DME_ST_GANY] == (guard_a_reg | guard_b_reg) &&
                       prdata[DME_ST_CANY] == (clip_a_reg | clip_b_reg);
  endproperty
  a_any_read: assert property (p_any_read) else $error("combined status bits wrong");

  property p_sat40;
    upd_a && sat_a && w40 && ov39 |=> clip_a_reg &&
      (acc_a_reg == DME_POS40 || acc_a_reg == DME_NEG40);
  endproperty
  a_sat40: assert property (p_sat40) else $error("40-bit saturation value wrong");

  property p_sat32;
    upd_a && sat_a && !w40 && ov31 |=> clip_a_reg && !guard_a_reg &&
      (acc_a_reg == DME_POS32 || acc_a_reg == DME_NEG32);
  endproperty
  a_sat32: assert property (p_sat32) else $error("32-bit saturation value wrong");

  property p_wrap;
    upd_a && !sat_a && ov39 |=> clip_a_reg && acc_a_reg == $past(sum[39:0]);
  endproperty
  a_wrap: assert property (p_wrap) else $error("catastrophic mode did not wrap");

  property p_postinc;
    wb_ind |=> xbus_wr_en && xbus_addr == $past(ptr_reg) &&
               ptr_reg == $past(ptr_reg) + DME_WB_STEP ##1 !xbus_wr_en;
  endproperty
  a_postinc: assert property (p_postinc) else $error("indirect write-back wrong");

  c_mac:     cover property (exec && op == DME_MAC);
  c_sat40:   cover property (upd_a && sat_a && w40 && ov39);
  c_wb_ind:  cover property (wb_ind);
  c_trap:    cover property (arith_trap);

endmodule

//--- dme_pkg.sv
package dme_pkg;

  // Register byte offsets
  localparam logic [7:0] DME_OFF_CFG    = 8'h00;
  localparam logic [7:0] DME_OFF_TRAP   = 8'h04;
  localparam logic [7:0] DME_OFF_STAT   = 8'h08;
  localparam logic [7:0] DME_OFF_ACCUMULATOR_A_L = 8'h0C;
  localparam logic [7:0] DME_OFF_ACCUMULATOR_A_H = 8'h10;
  localparam logic [7:0] DME_OFF_ACCUMULATOR_B_L = 8'h14;
  localparam logic [7:0] DME_OFF_ACCUMULATOR_B_H = 8'h18;
  localparam logic [7:0] DME_OFF_OPND   = 8'h1C;
  localparam logic [7:0] DME_OFF_CMD    = 8'h20;
  localparam logic [7:0] DME_OFF_IPROD  = 8'h24;
  localparam logic [7:0] DME_OFF_WBPTR  = 8'h28;

  // core_config_reg fields
  localparam int DME_CFG_FRAC   = 0;
  localparam int DME_CFG_UNS    = 1;
  localparam int DME_CFG_RND    = 2;
  localparam int DME_CFG_W40    = 4;
  localparam int DME_CFG_MWCLIP = 5;
  localparam int DME_CFG_CLIPB  = 6;
  localparam int DME_CFG_CLIPA  = 7;
  localparam logic [7:0] DME_CFG_RST = 8'h01;

  // trap_control_reg fields
  localparam int DME_TRAP_GA  = 0;
  localparam int DME_TRAP_GB  = 1;
  localparam int DME_TRAP_CAT = 2;
  localparam logic [2:0] DME_TRAP_RST = 3'h0;

  // Status fields
  localparam int DME_ST_GA    = 0;
  localparam int DME_ST_GB    = 1;
  localparam int DME_ST_CA    = 2;
  localparam int DME_ST_CB    = 3;
  localparam int DME_ST_GANY  = 4;
  localparam int DME_ST_CANY  = 5;
  localparam int DME_ST_TRAP  = 6;

  // Command fields
  localparam int DME_CMD_TGT   = 4;
  localparam int DME_CMD_WBM_L = 5;
  localparam int DME_CMD_SH_L  = 8;
  localparam int DME_CMD_XUNS  = 13;
  localparam int DME_CMD_YUNS  = 14;
  localparam int DME_CMD_BYTE  = 15;

  // Saturation values, write-back step and rounding half-point
  localparam logic [39:0] DME_POS40 = 40'h7F_FFFF_FFFF;
  localparam logic [39:0] DME_NEG40 = 40'h80_0000_0000;
  localparam logic [39:0] DME_POS32 = 40'h00_7FFF_FFFF;
  localparam logic [39:0] DME_NEG32 = 40'h00_8000_0000;
  localparam logic [15:0] DME_WB_STEP = 16'h0002;
  localparam logic [15:0] DME_HALF    = 16'h8000;

  typedef enum logic [3:0] {
    DME_NOP, DME_ZERO, DME_PLOAD, DME_NPLOAD, DME_MAC, DME_MSC, DME_SQAC, DME_DSQ,
    DME_DSQAC, DME_ALOAD, DME_AADD, DME_ACCADD, DME_ACCSUB, DME_ACCNEG, DME_IPROD,
    DME_PFSTORE
  } dme_op_e;

  typedef enum logic [1:0] {
    DME_WB_NONE = 2'b00,
    DME_WB_DIRECT = 2'b01,
    DME_WB_INDIRECT = 2'b10
  } dme_wb_e;

endpackage

//--- dme_xmem_model.sv
module dme_xmem_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // X bus store from the engine
  input  wire logic        wr_en,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  // What the memory saw
  output logic      [7:0]  wr_cnt,
  output logic      [15:0] last_addr,
  output logic      [15:0] last_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // Counting every sampled strobe exposes a store that is held too long
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_cnt    <= 8'h00;
      last_addr <= 16'h0000;
      last_data <= 16'h0000;
    end else if (wr_en) begin
      wr_cnt    <= wr_cnt + 8'h01;
      last_addr <= addr;
      last_data <= wdata;
    end
  end
endmodule

//--- testbench.sv
module testbench
  import dme_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr, wr_cnt;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, xbus_wr_en, arith_trap;
  logic [15:0] xbus_addr, xbus_wdata, last_addr, last_data;
  int          n_fail, checks_done;

  dme_mac_engine dme_mac_engine_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .xbus_wr_en(xbus_wr_en), .xbus_addr(xbus_addr),
    .xbus_wdata(xbus_wdata), .arith_trap(arith_trap));

  dme_xmem_model dme_xmem_model_inst (.pclk(pclk), .presetn(presetn), .wr_en(xbus_wr_en),
    .addr(xbus_addr), .wdata(xbus_wdata), .wr_cnt(wr_cnt), .last_addr(last_addr),
    .last_data(last_data));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One idle edge first, so a release and the next setup never share a time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) begin
      n_fail++;
      close_out();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = '1);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r & m, x);
  endtask

  task automatic acc_chk(input logic t, input logic [39:0] x);
    logic [31:0] lo, hi;
    logic        e;
    apb(1'b0, t ? DME_OFF_ACCUMULATOR_B_L : DME_OFF_ACCUMULATOR_A_L, 32'h0000_0000, lo, e);
    apb(1'b0, t ? DME_OFF_ACCUMULATOR_B_H : DME_OFF_ACCUMULATOR_A_H, 32'h0000_0000, hi, e);
    chk({hi[7:0], lo}, x);
  endtask

  function automatic logic [15:0] cm(input logic [3:0] op, input logic t,
                                     input logic [1:0] wb, input logic [4:0] sh,
                                     input logic [2:0] fl);
    return {fl, sh, 1'b0, wb, t, op};
  endfunction

  task automatic run(input logic [15:0] c, input logic [15:0] x, input logic [15:0] y);
    wr(DME_OFF_OPND, {y, x});
    wr(DME_OFF_CMD, {16'h0000, c});
  endtask

  task automatic step(input logic [3:0] op, input logic [15:0] x, y, input logic [39:0] v);
    run(cm(op, 1'b1, 2'b00, 5'h00, 3'b000), x, y);
    acc_chk(1'b1, v);
  endtask

  // Load then add the same operand on A, shifted, to force an overflow
  task automatic ovf(input logic [15:0] x, input logic [4:0] sh);
    run(cm(DME_ALOAD, 1'b0, 2'b00, sh, 3'b000), x, 16'h0000);
    run(cm(DME_AADD, 1'b0, 2'b00, sh, 3'b000), x, 16'h0000);
  endtask

  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    rdc(DME_OFF_CFG, {24'h00_0000, DME_CFG_RST});
    rdc(DME_OFF_TRAP, 32'h0000_0000);
    rdc(DME_OFF_STAT, 32'h0000_0000);
    wr(DME_OFF_CFG, 32'h0000_00FF);
    rdc(DME_OFF_CFG, 32'h0000_00FF);
    wr(DME_OFF_ACCUMULATOR_A_L, 32'hFFFF_FFFF);
    rdc(DME_OFF_ACCUMULATOR_A_L, 32'h0000_0000);
    apb(1'b0, 8'h2C, 32'h0000_0000, r, e);
    chk(e, 1'b1);
    chk(r, 32'h0000_0000);
  endtask

  task automatic t_mult();
    wr(DME_OFF_CFG, 32'h0000_0001);
    run(cm(DME_PLOAD, 1'b0, 2'b00, 5'h00, 3'b000), 16'h4000, 16'h4000);
    acc_chk(1'b0, 40'h00_2000_0000);
    run(cm(DME_PLOAD, 1'b0, 2'b00, 5'h00, 3'b000), 16'h8000, 16'h8000);
    acc_chk(1'b0, 40'h00_8000_0000);
    wr(DME_OFF_CFG, 32'h0000_0002);
    run(cm(DME_PLOAD, 1'b0, 2'b00, 5'h00, 3'b000), 16'hFFFF, 16'hFFFF);
    acc_chk(1'b0, 40'h00_FFFE_0001);
    wr(DME_OFF_CFG, 32'h0000_0000);
    run(cm(DME_PLOAD, 1'b0, 2'b00, 5'h00, 3'b000), 16'hFFFF, 16'h0002);
    acc_chk(1'b0, 40'hFF_FFFF_FFFE);
    run(cm(DME_IPROD, 1'b0, 2'b00, 5'h00, 3'b000), 16'hFFFF, 16'h0002);
    rdc(DME_OFF_IPROD, 32'hFFFF_FFFE);
    run(cm(DME_IPROD, 1'b0, 2'b00, 5'h00, 3'b001), 16'hFFFF, 16'h0002);
    rdc(DME_OFF_IPROD, 32'h0001_FFFE);
    run(cm(DME_IPROD, 1'b0, 2'b00, 5'h00, 3'b100), 16'hFFFF, 16'h0002);
    rdc(DME_OFF_IPROD, 32'h0000_FFFE);
  endtask

  task automatic t_ops();
    step(DME_ZERO, 16'h0000, 16'h0000, 40'h00_0000_0000);
    step(DME_PLOAD, 16'h0003, 16'h0005, 40'h00_0000_000F);
    step(DME_MAC, 16'h0002, 16'h0004, 40'h00_0000_0017);
    step(DME_MSC, 16'h0001, 16'h0003, 40'h00_0000_0014);
    step(DME_SQAC, 16'h0004, 16'h0000, 40'h00_0000_0024);
    step(DME_DSQ, 16'h0007, 16'h0004, 40'h00_0000_0009);
    step(DME_DSQAC, 16'h0002, 16'h0005, 40'h00_0000_0012);
    step(DME_NPLOAD, 16'h0003, 16'h0003, 40'hFF_FFFF_FFF7);
    acc_chk(1'b0, 40'hFF_FFFF_FFFE);
    run(cm(DME_ALOAD, 1'b0, 2'b00, 5'h00, 3'b000), 16'h0003, 16'h0000);
    acc_chk(1'b0, 40'h00_0003_0000);
    step(DME_ALOAD, 16'h0002, 16'h0000, 40'h00_0002_0000);
    run(cm(DME_ACCADD, 1'b0, 2'b00, 5'h00, 3'b000), 16'h0000, 16'h0000);
    acc_chk(1'b0, 40'h00_0005_0000);
    step(DME_ACCSUB, 16'h0000, 16'h0000, 40'hFF_FFFD_0000);
    step(DME_ACCNEG, 16'h0000, 16'h0000, 40'h00_0003_0000);
  endtask

  task automatic t_guard(input logic t);
    wr(DME_OFF_CFG, 32'h0000_0010);
    wr(DME_OFF_TRAP, {31'h0, 1'b1} << t);
    run(cm(DME_ALOAD, t, 2'b00, 5'h00, 3'b000), 16'h4000, 16'h0000);
    run(cm(DME_AADD, t, 2'b00, 5'h1E, 3'b000), 16'h4000, 16'h0000);
    acc_chk(t, 40'h01_4000_0000);
    rdc(DME_OFF_STAT, ({31'h0, 1'b1} << t) | 32'h0000_0010, 32'h0000_0013);
    chk(arith_trap, 1'b1);
    wr(DME_OFF_TRAP, {31'h0, 1'b1} << !t);
    rdc(DME_OFF_STAT, 32'h0000_0000, 32'h0000_000C);
    chk(arith_trap, 1'b0);
    run(cm(DME_AADD, t, 2'b00, 5'h1E, 3'b000), 16'hC000, 16'h0000);
    rdc(DME_OFF_STAT, 32'h0000_0000, 32'h0000_0013);
  endtask

  task automatic t_sat();
    wr(DME_OFF_TRAP, 32'h0000_0000);
    wr(DME_OFF_CFG, 32'h0000_0090);
    ovf(16'h7FFF, 5'h18);
    acc_chk(1'b0, DME_POS40);
    rdc(DME_OFF_STAT, 32'h0000_0024, 32'h0000_0024);
    run(cm(DME_ZERO, 1'b0, 2'b00, 5'h00, 3'b000), 16'h0000, 16'h0000);
    rdc(DME_OFF_STAT, 32'h0000_0004, 32'h0000_0004);
    wr(DME_OFF_STAT, 32'h0000_0004);
    rdc(DME_OFF_STAT, 32'h0000_0000, 32'h0000_0024);
    ovf(16'h8000, 5'h18);
    acc_chk(1'b0, DME_NEG40);
    wr(DME_OFF_STAT, 32'h0000_0004);
    wr(DME_OFF_CFG, 32'h0000_0080);
    run(cm(DME_ALOAD, 1'b0, 2'b00, 5'h00, 3'b000), 16'h7FFF, 16'h0000);
    run(cm(DME_AADD, 1'b0, 2'b00, 5'h1F, 3'b000), 16'h7FFF, 16'h0000);
    acc_chk(1'b0, DME_POS32);
    rdc(DME_OFF_STAT, 32'h0000_0024, 32'h0000_0035);
    wr(DME_OFF_STAT, 32'h0000_0004);
    wr(DME_OFF_CFG, 32'h0000_0010);
    wr(DME_OFF_TRAP, 32'h0000_0004);
    ovf(16'h7FFF, 5'h18);
    acc_chk(1'b0, 40'hFF_FE00_0000);
    rdc(DME_OFF_STAT, 32'h0000_0004, 32'h0000_0004);
    chk(arith_trap, 1'b1);
    wr(DME_OFF_STAT, 32'h0000_0004);
    wr(DME_OFF_TRAP, 32'h0000_0000);
  endtask

  task automatic t_wb();
    wr(DME_OFF_CFG, 32'h0000_0000);
    run(cm(DME_ALOAD, 1'b1, 2'b00, 5'h01, 3'b000), 16'h1235, 16'h0000);
    run(cm(DME_PFSTORE, 1'b0, 2'b01, 5'h00, 3'b000), 16'h0000, 16'h0000);
    rdc(DME_OFF_WBPTR, 32'h0000_091B);
    wr(DME_OFF_WBPTR, 32'h0000_0100);
    run(cm(DME_MAC, 1'b0, 2'b10, 5'h00, 3'b000), 16'h0000, 16'h0000);
    rdc(DME_OFF_WBPTR, 32'h0000_0102);
    chk(wr_cnt, 8'h01);
    chk({last_addr, last_data}, 32'h0100_091B);
    run(cm(DME_PLOAD, 1'b0, 2'b10, 5'h00, 3'b000), 16'h0000, 16'h0000);
    rdc(DME_OFF_WBPTR, 32'h0000_0102);
    chk(wr_cnt, 8'h01);
    wr(DME_OFF_CFG, 32'h0000_0004);
    run(cm(DME_PFSTORE, 1'b0, 2'b01, 5'h00, 3'b000), 16'h0000, 16'h0000);
    rdc(DME_OFF_WBPTR, 32'h0000_091A);
  endtask

  initial begin
    #500000;
    n_fail++;
    close_out();
  end

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_mult();
    t_ops();
    t_guard(1'b0);
    t_guard(1'b1);
    t_sat();
    t_wb();
    close_out();
  end
endmodule
